// File: hw/owd_pkg.sv
// Constants for the option word decoder: register map, field positions, reset words and timing.
package owd_pkg;

	localparam int unsigned WORD_W = 13;

	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] ADDR_WORD0  = 8'h00;
	localparam logic [7:0] ADDR_WORD1  = 8'h04;
	localparam logic [7:0] ADDR_WORD2  = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_CTRL   = 8'h10;

	// Register select codes.
	localparam logic [2:0] SEL_WORD0  = 3'h0;
	localparam logic [2:0] SEL_WORD1  = 3'h1;
	localparam logic [2:0] SEL_WORD2  = 3'h2;
	localparam logic [2:0] SEL_STATUS = 3'h3;
	localparam logic [2:0] SEL_CTRL   = 3'h4;
	localparam logic [2:0] SEL_NONE   = 3'h7;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Word 0 fields.
	localparam logic [12:0] W0_RSVD_MASK = 13'h1c00;
	localparam int unsigned W0_VARIANT   = 9;
	localparam int unsigned W0_PERIOD    = 8;
	localparam int unsigned W0_WDT_DIS_N = 7;
	localparam int unsigned W0_OSC_HI    = 6;
	localparam int unsigned W0_OSC_LO    = 4;
	localparam int unsigned W0_HIGH_PWR  = 3;
	localparam int unsigned W0_PROT_HI   = 2;
	localparam logic [2:0]  PROT_OFF     = 3'h7;

	// Oscillator mode codes.
	localparam logic [1:0] OSC_ERC_TOP = 2'h0;
	localparam logic [1:0] OSC_IRC_TOP = 2'h1;
	localparam logic [2:0] OSC_LXT     = 3'h6;

	// Word 1 fields.
	localparam logic [12:0] W1_RSVD_MASK = 13'h1800;
	localparam int unsigned W1_CLK_OUT   = 10;
	localparam int unsigned W1_NOISE_W   = 9;
	localparam int unsigned W1_NOISE_EN  = 8;
	localparam int unsigned W1_WDT_SEL   = 7;
	localparam int unsigned W1_PC_CYC    = 6;
	localparam int unsigned W1_IRC_HI    = 1;

	// Words held before the non-volatile values are captured.
	localparam logic [12:0] W0_RESET = 13'h1fff;
	localparam logic [12:0] W1_RESET = 13'h1fff;
	localparam logic [12:0] W2_RESET = 13'h0000;

	// Timing.
	localparam int unsigned CLK_KHZ      = 40000;
	localparam int unsigned WDT_LONG_US  = 18000;
	localparam int unsigned WDT_SHORT_US = 4500;
	localparam logic [5:0]  NOISE_SHORT_FC = 6'h08;
	localparam logic [5:0]  NOISE_LONG_FC  = 6'h20;
	localparam logic [2:0]  PERIOD_SHORT   = 3'h2;
	localparam logic [2:0]  PERIOD_LONG    = 3'h4;
	localparam logic [13:0] IRC_KHZ_4M   = 14'h0fa0;
	localparam logic [13:0] IRC_KHZ_8M   = 14'h1f40;
	localparam logic [13:0] IRC_KHZ_1M   = 14'h03e8;
	localparam logic [13:0] IRC_KHZ_455K = 14'h01c7;

	// Instruction fields.
	localparam logic [5:0] PC_REG_ADDR  = 6'h02;
	localparam logic [1:0] GRP_REG_OP   = 2'h0;
	localparam logic [1:0] GRP_BIT_OP   = 2'h1;

endpackage : owd_pkg

// File: hw/owd_decoder.sv
// Option word decoder: captures the configuration words and drives the chip settings.

// Contract
// - Word 0 bits 12 to 10 always read as one.
// - Word 0 bit 9 picks the package variant, one is default.
// - Word 0 bit 8 sets two or four oscillator periods per instruction.
// - Word 0 bit 7 low enables the watchdog, high disables it.
// - Word 0 bits 6 to 4 pick external RC, internal RC, or crystal mode.
// - In RC modes oscillator bit 0 makes the shared output pin I/O or clock.
// - In crystal modes both oscillator pins never act as general I/O.
// - In internal RC mode the oscillator input pin is general I/O.
// - Word 0 bit 3 selects low or high power class.
// - Code protection is off only when word 0 bits 2 to 0 are all ones.
// - Word 1 bits 12 and 11 always read as one.
// - In RC modes word 1 bit 10 picks open drain or clock out.
// - Word 1 bit 9 picks an 8 or 32 clock minimum interrupt pulse.
// - Word 1 bit 8 enables the interrupt noise filter.
// - Noise filter is forced off in low crystal mode and in sleep.
// - Word 1 bit 7 picks a 4.5 ms or 18 ms watchdog timeout.
// - Word 1 bit 6 picks one or two cycles for counter writes.
// - Word 1 bits 1 and 0 pick the internal RC frequency.
// - Word 2 is a free customer code with no effect.
// - Instructions are 13-bit words and normally take one cycle.
// - Instructions writing the program counter take one or two cycles.
// - Bit set, clear and test reach any register, I/O included.
module owd_decoder #(
	parameter int unsigned ADDR_W        = 8,
	parameter int unsigned WDT_LONG_CYC  = owd_pkg::WDT_LONG_US * (owd_pkg::CLK_KHZ / 1000),
	parameter int unsigned WDT_SHORT_CYC = owd_pkg::WDT_SHORT_US * (owd_pkg::CLK_KHZ / 1000)
) (
	// Clock and reset.
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst_b,
	// Non-volatile configuration words.
	input  wire logic [12:0]        i_nvm_word0,
	input  wire logic [12:0]        i_nvm_word1,
	input  wire logic [12:0]        i_nvm_word2,
	// Core status and instruction stream.
	input  wire logic               i_sleep,
	input  wire logic [12:0]        i_instr,
	input  wire logic               i_instr_valid,
	// AXI4-Lite write channels.
	input  wire logic [ADDR_W-1:0]  i_awaddr,
	input  wire logic               i_awvalid,
	output logic                    o_awready,
	input  wire logic [31:0]        i_wdata,
	input  wire logic [3:0]         i_wstrb,
	input  wire logic               i_wvalid,
	output logic                    o_wready,
	output logic [1:0]              o_bresp,
	output logic                    o_bvalid,
	input  wire logic               i_bready,
	// AXI4-Lite read channels.
	input  wire logic [ADDR_W-1:0]  i_araddr,
	input  wire logic               i_arvalid,
	output logic                    o_arready,
	output logic [31:0]             o_rdata,
	output logic [1:0]              o_rresp,
	output logic                    o_rvalid,
	input  wire logic               i_rready,
	// Decoded settings.
	output logic                    o_config_valid,
	output logic                    o_variant_default,
	output logic                    o_instr_period_four,
	output logic                    o_watchdog_enable,
	output logic                    o_osc_erc,
	output logic                    o_osc_irc,
	output logic                    o_osc_lxt,
	output logic                    o_osc_hxt,
	output logic                    o_osc_out_is_io,
	output logic                    o_osc_in_is_io,
	output logic                    o_osc_out_clk_en,
	output logic                    o_osc_out_open_drain,
	output logic                    o_high_power,
	output logic                    o_code_protect,
	output logic                    o_noise_filter_on,
	output logic [5:0]              o_noise_min_width,
	output logic [19:0]             o_wdt_timeout_cyc,
	output logic                    o_pc_write_two_cycles,
	output logic [13:0]             o_irc_freq_khz,
	// Instruction timing and bit operations.
	output logic                    o_instr_cycle_en,
	output logic                    o_instr_pc_write,
	output logic [1:0]              o_instr_cycles,
	output logic                    o_bit_op_valid,
	output logic [1:0]              o_bit_op,
	output logic [2:0]              o_bit_index,
	output logic [5:0]              o_bit_reg_addr
);

	typedef struct packed {
		logic        loaded;
		logic [12:0] word0;
		logic [12:0] word1;
		logic [12:0] word2;
		logic        ctrl_sleep;
		logic        awready;
		logic        wready;
		logic        aw_held;
		logic        w_held;
		logic [7:0]  aw_addr;
		logic        w_sleep;
		logic        w_lane0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        cfg_valid;
		logic        variant;
		logic        period_four;
		logic        wdt_en;
		logic        external_rc_osc;
		logic        internal_rc_osc;
		logic        low_crystal_mode;
		logic        high_crystal_mode;
		logic        out_io;
		logic        in_io;
		logic        out_clk;
		logic        out_od;
		logic        high_pwr;
		logic        protect;
		logic        nf_on;
		logic [5:0]  nf_width;
		logic [19:0] wdt_cyc;
		logic        pc_two;
		logic [13:0] irc_khz;
		logic [2:0]  div_cnt;
		logic        cyc_en;
		logic        pc_write;
		logic [1:0]  cycles;
		logic        bit_valid;
		logic [1:0]  bit_op;
		logic [2:0]  bit_idx;
		logic [5:0]  bit_reg;
	} owd_state_type;

	owd_state_type st;
	owd_state_type next_st;

	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		unique case (a)
			owd_pkg::ADDR_WORD0:  reg_sel = owd_pkg::SEL_WORD0;
			owd_pkg::ADDR_WORD1:  reg_sel = owd_pkg::SEL_WORD1;
			owd_pkg::ADDR_WORD2:  reg_sel = owd_pkg::SEL_WORD2;
			owd_pkg::ADDR_STATUS: reg_sel = owd_pkg::SEL_STATUS;
			owd_pkg::ADDR_CTRL:   reg_sel = owd_pkg::SEL_CTRL;
			default:              reg_sel = owd_pkg::SEL_NONE;
		endcase
	endfunction : reg_sel

	// Register-destination ops carry the destination flag in bit 6; bit set and clear share bits 12 to 10.
	function automatic logic writes_pc(input logic [12:0] ins);
		logic reg_op;
		logic bit_wr;
		reg_op = (ins[12:11] == owd_pkg::GRP_REG_OP) && ins[6];
		bit_wr = (ins[12:11] == owd_pkg::GRP_BIT_OP) && !ins[10];
		writes_pc = (reg_op || bit_wr) && (ins[5:0] == owd_pkg::PC_REG_ADDR);
	endfunction : writes_pc

	always_comb begin
		logic [2:0] osc;
		logic       rc;
		logic       low_crystal_mode;
		logic       sleep_eff;
		logic [2:0] per;
		logic [2:0] rsel;
		logic [2:0] wsel;
		osc       = st.word0[owd_pkg::W0_OSC_HI:owd_pkg::W0_OSC_LO];
		rc        = (osc[2:1] == owd_pkg::OSC_ERC_TOP) || (osc[2:1] == owd_pkg::OSC_IRC_TOP);
		low_crystal_mode       = (osc == owd_pkg::OSC_LXT);
		sleep_eff = i_sleep || st.ctrl_sleep;
		per       = st.period_four ? owd_pkg::PERIOD_LONG : owd_pkg::PERIOD_SHORT;
		rsel      = reg_sel(i_araddr[7:0]);
		wsel      = reg_sel(st.aw_addr);
		next_st   = st;
		next_st.cyc_en = 1'b0;

		// Capture once, one edge after reset release; the words never change afterwards.
		if (!st.loaded) begin
			next_st.loaded = 1'b1;
			next_st.word0  = i_nvm_word0 | owd_pkg::W0_RSVD_MASK;
			next_st.word1  = i_nvm_word1 | owd_pkg::W1_RSVD_MASK;
			next_st.word2  = i_nvm_word2;
		end

		if (st.loaded) begin
			next_st.cfg_valid   = 1'b1;
			next_st.variant     = st.word0[owd_pkg::W0_VARIANT];
			next_st.period_four = st.word0[owd_pkg::W0_PERIOD];
			next_st.wdt_en      = !st.word0[owd_pkg::W0_WDT_DIS_N];
			next_st.external_rc_osc         = (osc[2:1] == owd_pkg::OSC_ERC_TOP);
			next_st.internal_rc_osc         = (osc[2:1] == owd_pkg::OSC_IRC_TOP);
			next_st.low_crystal_mode         = low_crystal_mode;
			// The two unlisted codes fall to high crystal, which keeps both pins off the I/O ports.
			next_st.high_crystal_mode         = !rc && !low_crystal_mode;
			next_st.out_io      = rc && !osc[0];
			next_st.in_io       = (osc[2:1] == owd_pkg::OSC_IRC_TOP);
			next_st.out_clk     = rc && osc[0] && st.word1[owd_pkg::W1_CLK_OUT];
			next_st.out_od      = rc && osc[0] && !st.word1[owd_pkg::W1_CLK_OUT];
			next_st.high_pwr    = st.word0[owd_pkg::W0_HIGH_PWR];
			next_st.protect     = (st.word0[owd_pkg::W0_PROT_HI:0] != owd_pkg::PROT_OFF);
			next_st.nf_on       = st.word1[owd_pkg::W1_NOISE_EN] && !low_crystal_mode && !sleep_eff;
			next_st.nf_width    = st.word1[owd_pkg::W1_NOISE_W] ? owd_pkg::NOISE_LONG_FC
				: owd_pkg::NOISE_SHORT_FC;
			next_st.wdt_cyc     = st.word1[owd_pkg::W1_WDT_SEL] ? 20'(WDT_LONG_CYC)
				: 20'(WDT_SHORT_CYC);
			next_st.pc_two      = st.word1[owd_pkg::W1_PC_CYC];
			unique case (st.word1[owd_pkg::W1_IRC_HI:0])
				2'h3:    next_st.irc_khz = owd_pkg::IRC_KHZ_4M;
				2'h2:    next_st.irc_khz = owd_pkg::IRC_KHZ_8M;
				2'h1:    next_st.irc_khz = owd_pkg::IRC_KHZ_1M;
				default: next_st.irc_khz = owd_pkg::IRC_KHZ_455K;
			endcase
		end

		// Instruction cycle strobe; the >= guard recovers if the period shrinks mid-count.
		if (st.cfg_valid) begin
			if (st.div_cnt >= per - 3'h1) begin
				next_st.div_cnt = 3'h0;
				next_st.cyc_en  = 1'b1;
			end else begin
				next_st.div_cnt = st.div_cnt + 3'h1;
			end
		end

		// Per-instruction timing and bit-operation decode.
		next_st.pc_write  = 1'b0;
		next_st.bit_valid = 1'b0;
		if (i_instr_valid) begin
			next_st.pc_write = writes_pc(i_instr);
			next_st.cycles   = (writes_pc(i_instr) && st.pc_two) ? 2'h2 : 2'h1;
			if (i_instr[12:11] == owd_pkg::GRP_BIT_OP) begin
				next_st.bit_valid = 1'b1;
				next_st.bit_op    = i_instr[10:9];
				next_st.bit_idx   = i_instr[8:6];
				next_st.bit_reg   = i_instr[5:0];
			end
		end

		// AXI write: address and data taken in either order, answered when both are held.
		if (i_awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = i_awaddr[7:0];
		end
		if (i_wvalid && st.wready) begin
			next_st.w_held  = 1'b1;
			next_st.w_sleep = i_wdata[0];
			next_st.w_lane0 = i_wstrb[0];
		end
		if (st.bvalid && i_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			if (wsel == owd_pkg::SEL_CTRL) begin
				next_st.bresp = owd_pkg::RESP_OKAY;
				if (st.w_lane0) begin
					next_st.ctrl_sleep = st.w_sleep;
				end
			end else if (wsel == owd_pkg::SEL_NONE) begin
				next_st.bresp = owd_pkg::RESP_DECERR;
			end else begin
				next_st.bresp = owd_pkg::RESP_SLVERR;
			end
		end
		next_st.awready = !next_st.aw_held && !next_st.bvalid;
		next_st.wready  = !next_st.w_held && !next_st.bvalid;

		// AXI read.
		if (st.rvalid && i_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (i_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = owd_pkg::RESP_OKAY;
			next_st.rdata  = 32'h0000_0000;
			unique case (rsel)
				owd_pkg::SEL_WORD0:  next_st.rdata[12:0] = st.word0;
				owd_pkg::SEL_WORD1:  next_st.rdata[12:0] = st.word1;
				owd_pkg::SEL_WORD2:  next_st.rdata[12:0] = st.word2;
				owd_pkg::SEL_STATUS: next_st.rdata[7:0]  = {sleep_eff, st.nf_on, st.wdt_en,
					st.protect, st.low_crystal_mode || st.high_crystal_mode, st.internal_rc_osc, st.external_rc_osc, st.cfg_valid};
				owd_pkg::SEL_CTRL:   next_st.rdata[0]    = st.ctrl_sleep;
				default:             next_st.rresp       = owd_pkg::RESP_DECERR;
			endcase
		end
		next_st.arready = !next_st.rvalid;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st             <= '0;
			st.word0       <= owd_pkg::W0_RESET;
			st.word1       <= owd_pkg::W1_RESET;
			st.word2       <= owd_pkg::W2_RESET;
			st.awready     <= 1'b1;
			st.wready      <= 1'b1;
			st.arready     <= 1'b1;
			st.variant     <= 1'b1;
			st.period_four <= 1'b1;
			st.high_crystal_mode         <= 1'b1;
			st.protect     <= 1'b1;
			st.nf_width    <= owd_pkg::NOISE_LONG_FC;
			st.wdt_cyc     <= 20'(WDT_LONG_CYC);
			st.pc_two      <= 1'b1;
			st.irc_khz     <= owd_pkg::IRC_KHZ_4M;
			st.cycles      <= 2'h1;
		end else begin
			st <= next_st;
		end
	end

	assign o_awready             = st.awready;
	assign o_wready              = st.wready;
	assign o_bresp               = st.bresp;
	assign o_bvalid              = st.bvalid;
	assign o_arready             = st.arready;
	assign o_rdata               = st.rdata;
	assign o_rresp               = st.rresp;
	assign o_rvalid              = st.rvalid;
	assign o_config_valid        = st.cfg_valid;
	assign o_variant_default     = st.variant;
	assign o_instr_period_four   = st.period_four;
	assign o_watchdog_enable     = st.wdt_en;
	assign o_osc_erc             = st.external_rc_osc;
	assign o_osc_irc             = st.internal_rc_osc;
	assign o_osc_lxt             = st.low_crystal_mode;
	assign o_osc_hxt             = st.high_crystal_mode;
	assign o_osc_out_is_io       = st.out_io;
	assign o_osc_in_is_io        = st.in_io;
	assign o_osc_out_clk_en      = st.out_clk;
	assign o_osc_out_open_drain  = st.out_od;
	assign o_high_power          = st.high_pwr;
	assign o_code_protect        = st.protect;
	assign o_noise_filter_on     = st.nf_on;
	assign o_noise_min_width     = st.nf_width;
	assign o_wdt_timeout_cyc     = st.wdt_cyc;
	assign o_pc_write_two_cycles = st.pc_two;
	assign o_irc_freq_khz        = st.irc_khz;
	assign o_instr_cycle_en      = st.cyc_en;
	assign o_instr_pc_write      = st.pc_write;
	assign o_instr_cycles        = st.cycles;
	assign o_bit_op_valid        = st.bit_valid;
	assign o_bit_op              = st.bit_op;
	assign o_bit_index           = st.bit_idx;
	assign o_bit_reg_addr        = st.bit_reg;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);

	reserved_bits_a: assert property (i_arvalid && o_arready && o_config_valid
		&& i_araddr[7:0] == owd_pkg::ADDR_WORD0 |=> o_rdata[12:10] == 3'h7 && o_rvalid)
		else $error("word 0 reserved bits not read as one");
	variant_sel_a: assert property (o_config_valid |-> o_variant_default == st.word0[9])
		else $error("variant select does not follow word 0");
	period_four_a: assert property (o_instr_cycle_en && o_instr_period_four && $past(o_config_valid, 2)
		|=> !o_instr_cycle_en [*3] ##1 o_instr_cycle_en)
		else $error("four-period instruction strobe spacing wrong");
	period_two_a: assert property (o_instr_cycle_en && !o_instr_period_four && $past(o_config_valid, 2)
		|=> !o_instr_cycle_en ##1 o_instr_cycle_en)
		else $error("two-period instruction strobe spacing wrong");
	wdt_enable_a: assert property (o_config_valid |-> o_watchdog_enable != st.word0[7])
		else $error("watchdog enable polarity wrong");
	crystal_pins_a: assert property (o_config_valid && (o_osc_lxt || o_osc_hxt)
		|-> !o_osc_out_is_io && !o_osc_in_is_io && !o_osc_out_clk_en && !o_osc_out_open_drain)
		else $error("crystal pin used as general I/O");
	irc_in_pin_a: assert property (o_config_valid && o_osc_irc |-> o_osc_in_is_io)
		else $error("internal RC input pin not general I/O");
	protect_bits_a: assert property (o_config_valid |-> o_code_protect != (&st.word0[2:0]))
		else $error("code protection decode wrong");
	noise_off_a: assert property (o_noise_filter_on |-> !o_osc_lxt && !$past(i_sleep))
		else $error("noise filter on in low crystal mode or sleep");
	pc_cycles_a: assert property (i_instr_valid && writes_pc(i_instr) && o_pc_write_two_cycles
		|=> o_instr_cycles == 2'h2 && o_instr_pc_write)
		else $error("counter write not given two cycles");
	word_write_a: assert property (o_bvalid && !$past(o_bvalid)
		&& $past(st.aw_addr) == owd_pkg::ADDR_WORD0 |-> o_bresp == owd_pkg::RESP_SLVERR)
		else $error("write to configuration word not refused");

	crystal_high_c: cover property (o_config_valid && o_osc_hxt && o_code_protect);
	irc_two_cyc_c: cover property (o_osc_irc && o_instr_pc_write && o_instr_cycles == 2'h2);
	sleep_filter_c: cover property (o_config_valid && $fell(o_noise_filter_on));
	slverr_c: cover property (o_bvalid && o_bresp == owd_pkg::RESP_SLVERR);

endmodule : owd_decoder

// File: tb/owd_decoder_test.sv
// Self-checking testbench for the option word decoder.
module owd_decoder_test;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int WDT_L = 40;
	localparam int WDT_S = 10;

	logic        i_clk_sys = 1'b0, i_rst_b = 1'b0, i_sleep = 1'b0, i_instr_valid = 1'b0;
	logic [12:0] i_nvm_word0 = 13'h1fff, i_nvm_word1 = 13'h1fff, i_nvm_word2 = 13'h0a5a, i_instr = 13'h0000;
	logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic [3:0]  i_wstrb = 4'h0;
	logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0]  o_bresp, o_rresp, o_instr_cycles, o_bit_op;
	logic [31:0] o_rdata;
	logic        o_config_valid, o_variant_default, o_instr_period_four, o_watchdog_enable, o_osc_erc, o_osc_irc;
	logic        o_osc_lxt, o_osc_hxt, o_osc_out_is_io, o_osc_in_is_io, o_osc_out_clk_en, o_osc_out_open_drain;
	logic        o_high_power, o_code_protect, o_noise_filter_on, o_pc_write_two_cycles, o_instr_cycle_en;
	logic        o_instr_pc_write, o_bit_op_valid;
	logic [5:0]  o_noise_min_width, o_bit_reg_addr;
	logic [19:0] o_wdt_timeout_cyc;
	logic [13:0] o_irc_freq_khz;
	logic [2:0]  o_bit_index;
	int          errors = 0, checked = 0, cycles = 0;

	// Short watchdog counts keep the run brief; expectations use the same figures.
	owd_decoder #(.WDT_LONG_CYC(WDT_L), .WDT_SHORT_CYC(WDT_S)) dut_u (
		.i_clk_sys, .i_rst_b, .i_nvm_word0, .i_nvm_word1, .i_nvm_word2, .i_sleep, .i_instr, .i_instr_valid,
		.i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
		.i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
		.o_config_valid, .o_variant_default, .o_instr_period_four, .o_watchdog_enable, .o_osc_erc, .o_osc_irc,
		.o_osc_lxt, .o_osc_hxt, .o_osc_out_is_io, .o_osc_in_is_io, .o_osc_out_clk_en, .o_osc_out_open_drain,
		.o_high_power, .o_code_protect, .o_noise_filter_on, .o_noise_min_width, .o_wdt_timeout_cyc,
		.o_pc_write_two_cycles, .o_irc_freq_khz, .o_instr_cycle_en, .o_instr_pc_write, .o_instr_cycles,
		.o_bit_op_valid, .o_bit_op, .o_bit_index, .o_bit_reg_addr
	);

	always #12.5 i_clk_sys = ~i_clk_sys;

	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			end_sim();
		end
	end

	task end_sim();
		if (errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk

	// Readies are looked at on the falling edge, so the handshake edge itself never races the check.
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge i_clk_sys);
		i_awaddr <= a;
		i_wdata <= d;
		i_wstrb <= 4'hf;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge i_clk_sys);
			ta = i_awvalid && o_awready;
			tw = i_wvalid && o_wready;
			tb = o_bvalid;
			r = o_bresp;
			@(posedge i_clk_sys);
			if (ta) i_awvalid <= 1'b0;
			if (tw) i_wvalid <= 1'b0;
			if (tb) i_bready <= 1'b0;
		end
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge i_clk_sys);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge i_clk_sys);
			ta = i_arvalid && o_arready;
			tr = o_rvalid;
			d = o_rdata;
			r = o_rresp;
			@(posedge i_clk_sys);
			if (ta) i_arvalid <= 1'b0;
			if (tr) i_rready <= 1'b0;
		end
	endtask : axi_rd

	task instr_test(input logic two);
		logic [12:0] ops [5] = '{13'h0042, 13'h0043, 13'h08c5, 13'h0b82, 13'h0fc7};
		for (int k = 0; k < 5; k++) begin
			@(posedge i_clk_sys);
			i_instr <= ops[k];
			i_instr_valid <= 1'b1;
			@(posedge i_clk_sys);
			i_instr_valid <= 1'b0;
			@(negedge i_clk_sys);
			chk(o_instr_pc_write, k == 0 || k == 3);
			chk(o_instr_cycles, ((k == 0 || k == 3) && two) ? 2'h2 : 2'h1);
			chk(o_bit_op_valid, k >= 2);
			if (k >= 2) chk({o_bit_op, o_bit_index, o_bit_reg_addr}, ops[k][10:0]);
		end
	endtask : instr_test

	task cfg_test(input logic [12:0] w0, input logic [12:0] w1);
		logic [13:0] khz [4] = '{14'h01c7, 14'h03e8, 14'h1f40, 14'h0fa0};
		logic        low_crystal_mode, rc, internal_rc_osc;
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		@(posedge i_clk_sys);
		i_rst_b <= 1'b0;
		i_nvm_word0 <= w0;
		i_nvm_word1 <= w1;
		repeat (6) @(posedge i_clk_sys);
		chk(o_config_valid, 1'b0);
		chk({o_awready, o_wready, o_arready, o_bvalid, o_rvalid}, 5'b11100);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		low_crystal_mode = w0[6:4] == 3'h6;
		internal_rc_osc = w0[6:5] == 2'h1;
		rc = !w0[6];
		chk(o_config_valid, 1'b1);
		chk(o_variant_default, w0[9]);
		chk(o_instr_period_four, w0[8]);
		chk(o_watchdog_enable, !w0[7]);
		chk({o_osc_erc, o_osc_irc, o_osc_lxt, o_osc_hxt}, {w0[6:5] == 2'h0, internal_rc_osc, low_crystal_mode, w0[6] && !low_crystal_mode});
		chk({o_osc_out_is_io, o_osc_in_is_io}, {rc && !w0[4], internal_rc_osc});
		chk({o_osc_out_clk_en, o_osc_out_open_drain}, {rc && w0[4] && w1[10], rc && w0[4] && !w1[10]});
		chk(o_high_power, w0[3]);
		chk(o_code_protect, w0[2:0] != 3'h7);
		chk(o_noise_filter_on, w1[8] && !low_crystal_mode);
		chk(o_noise_min_width, w1[9] ? 6'h20 : 6'h08);
		chk(o_wdt_timeout_cyc, w1[7] ? WDT_L : WDT_S);
		chk(o_pc_write_two_cycles, w1[6]);
		chk(o_irc_freq_khz, khz[w1[1:0]]);
		axi_rd(owd_pkg::ADDR_WORD0, d, r);
		chk(d, {19'h0_0000, w0 | 13'h1c00});
		axi_rd(owd_pkg::ADDR_WORD1, d, r);
		chk(d, {19'h0_0000, w1 | 13'h1800});
		axi_rd(owd_pkg::ADDR_WORD2, d, r);
		chk(d, {19'h0_0000, 13'h0a5a});
		chk(r, owd_pkg::RESP_OKAY);
		n = 0;
		repeat (16) begin
			@(negedge i_clk_sys);
			n += int'(o_instr_cycle_en === 1'b1);
		end
		chk(n, w0[8] ? 4 : 8);
		instr_test(w1[6]);
	endtask : cfg_test

	task misc_test();
		logic [31:0] d;
		logic [1:0]  r;
		@(posedge i_clk_sys);
		i_nvm_word0 <= 13'h0000;
		axi_wr(owd_pkg::ADDR_WORD0, 32'h0000_0000, r);
		chk(r, owd_pkg::RESP_SLVERR);
		axi_rd(owd_pkg::ADDR_WORD0, d, r);
		chk(d, 32'h0000_1fff);
		axi_rd(8'h40, d, r);
		chk(d, 32'h0000_0000);
		chk(r, owd_pkg::RESP_DECERR);
		i_sleep <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk(o_noise_filter_on, 1'b0);
		@(posedge i_clk_sys);
		i_sleep <= 1'b0;
		axi_wr(owd_pkg::ADDR_CTRL, 32'h0000_0001, r);
		chk(r, owd_pkg::RESP_OKAY);
		repeat (2) @(negedge i_clk_sys);
		chk(o_noise_filter_on, 1'b0);
		axi_rd(owd_pkg::ADDR_CTRL, d, r);
		chk(d, 32'h0000_0001);
		axi_rd(owd_pkg::ADDR_STATUS, d, r);
		chk(d, 32'h0000_0089);
		chk(r, owd_pkg::RESP_OKAY);
		axi_wr(owd_pkg::ADDR_CTRL, 32'h0000_0000, r);
		repeat (2) @(negedge i_clk_sys);
		chk(o_noise_filter_on, 1'b1);
	endtask : misc_test

	// Calibration bits stay at one in every programmed word 1.
	logic [25:0] cf [8] = '{{13'h1fff, 13'h1fff}, {13'h0000, 13'h003c}, {13'h0016, 13'h043d},
		{13'h0025, 13'h013e}, {13'h0037, 13'h003f}, {13'h006f, 13'h1fff}, {13'h004b, 13'h02bc},
		{13'h1fff, 13'h1fff}};

	initial begin
		for (int i = 0; i < 8; i++) cfg_test(cf[i][25:13], cf[i][12:0]);
		misc_test();
		end_sim();
	end
endmodule : owd_decoder_test
